/* File: rtl/pmir_params.svh */
`ifndef PMIR_PARAMS_SVH
`define PMIR_PARAMS_SVH

`define PMIR_OFF_IDENT_LOW 8'h00
`define PMIR_OFF_IDENT_HIGH 8'h01
`define PMIR_OFF_INT_FLAGS 8'h02
`define PMIR_OFF_INT_MASK 8'h03
`define PMIR_OFF_CHIP_STATUS 8'h04
`define PMIR_OFF_SHUTDOWN_CAUSE 8'h05

`define PMIR_FLAGS_RESET 8'h00
`define PMIR_MASK_RESET 8'hFF
`define PMIR_STATUS_RESET 8'h00
`define PMIR_CAUSE_RESET 4'h0

`define PMIR_BIT_FAULT 7
`define PMIR_BIT_SHUTDOWN 3
`define PMIR_BIT_HOT_DIE 0
`define PMIR_IMPL_BITS 8'h89

`define PMIR_CAUSE_COLD 3
`define PMIR_CAUSE_UVLO 2
`define PMIR_CAUSE_PWR 1
`define PMIR_CAUSE_CRIT 0

// Identity values, arbitrary
`define PMIR_PART_NUMBER 12'h5A3
`define PMIR_SILICON_REVISION 2'h2
`define PMIR_VARIANT 2'h1

`endif

/* File: rtl/pmir_pkg.sv */
package pmir_pkg;
    typedef logic [7:0] pmir_byte_t;
    typedef enum logic [1:0] {
        PMIR_VARIANT_A,
        PMIR_VARIANT_B,
        PMIR_VARIANT_C,
        PMIR_VARIANT_D
    } pmir_variant_e;
endpackage : pmir_pkg

/* File: rtl/pmir_edge_detect.sv */
`timescale 1ns/10ps
module pmir_edge_detect
(
    input wire logic clk, // System clock
    input wire logic resetn, // Sync reset, active low
    input wire logic level_in, // Level to watch
    output logic rise_out // One-cycle pulse on rising edge
);
    logic level_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            level_r <= 1'b0;
        else
            level_r <= level_in;
    end

    assign rise_out = level_in & ~level_r;
endmodule : pmir_edge_detect

/* File: rtl/pmir_regs.sv */
`timescale 1ns/10ps
`include "pmir_params.svh"
// How it works
// - Ident low byte holds part number bits 7:4 and 3:0, read-only.
// - Interrupt flags at 02h, reset to zero.
// - Fault flag bit 7 sets on a rising edge of (rail fault OR critical temperature).
// - Shutdown flag bit 3 sets when the device shuts down.
// - Shutdown flag cannot clear while any shutdown cause bit is set.
// - Hot-die flag bit 0 sets when die crosses above hot threshold.
// - Flags latch until host writes one; zero writes leave them.
// - Mask register at 03h resets to all ones.
// - Mask bits 7, 3, 0 gate fault, shutdown, hot-die; one masks.
// - Status register at 04h, read-only, reset zero, bit 0 live hot state.
// - Live hot bit follows temperature, not latched.
// - Any shutdown cause bit being set also sets shutdown flag.
module pmir_regs
(
    input wire logic clk, // System clock
    input wire logic resetn, // Sync reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe
    input wire pmir_pkg::pmir_byte_t reg_wdata, // Write data
    output pmir_pkg::pmir_byte_t reg_rdata, // Read data, registered
    input wire logic rail_fault, // Any rail power fault, level
    input wire logic crit_temp, // Die above critical threshold
    input wire logic hot_temp, // Die above hot threshold
    input wire logic uvlo_event, // Undervoltage shutdown event pulse
    input wire logic shutdown_event, // Device shutdown pulse
    output logic [3:0] shutdown_cause, // Shutdown cause bits
    output logic interrupt_out_n // Interrupt output, active low
);
    import pmir_pkg::*;

    pmir_byte_t flags_r;
    pmir_byte_t mask_r;
    pmir_byte_t status_r;
    logic [3:0] cause_r;
    logic fault_rise;
    logic crit_rise;
    logic hot_rise;
    logic wr_flags;
    logic wr_mask;
    logic wr_cause;
    pmir_byte_t clr_flags;
    logic [3:0] cause_set;
    logic cause_new;
    logic fault_lvl;
    logic irq_nxt;
    pmir_byte_t rdata_nxt;
    pmir_variant_e variant;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign variant = pmir_variant_e'(`PMIR_VARIANT);
    assign fault_lvl = rail_fault | crit_temp;

    pmir_edge_detect u_fault_edge (.clk(clk), .resetn(resetn), .level_in(fault_lvl), .rise_out(fault_rise));
    pmir_edge_detect u_crit_edge (.clk(clk), .resetn(resetn), .level_in(crit_temp), .rise_out(crit_rise));
    pmir_edge_detect u_hot_edge (.clk(clk), .resetn(resetn), .level_in(hot_temp), .rise_out(hot_rise));

    assign wr_flags = reg_wr & hit(reg_addr, `PMIR_OFF_INT_FLAGS);
    assign wr_mask = reg_wr & hit(reg_addr, `PMIR_OFF_INT_MASK);
    assign wr_cause = reg_wr & hit(reg_addr, `PMIR_OFF_SHUTDOWN_CAUSE);

    always_comb
    begin
        cause_set = 4'h0;
        cause_set[`PMIR_CAUSE_UVLO] = uvlo_event;
        cause_set[`PMIR_CAUSE_PWR] = shutdown_event & rail_fault;
        cause_set[`PMIR_CAUSE_CRIT] = crit_rise;
    end
    assign cause_new = |cause_set;

    // Shutdown cause, write one to clear, set wins
    always_ff @(posedge clk)
    begin
        if (!resetn)
            cause_r <= `PMIR_CAUSE_RESET;
        else if (wr_cause)
            cause_r <= (cause_r & ~reg_wdata[3:0]) | cause_set;
        else
            cause_r <= cause_r | cause_set;
    end

    always_comb
    begin
        clr_flags = wr_flags ? (reg_wdata & `PMIR_IMPL_BITS) : 8'h00;
        if (cause_r != 4'h0)
            clr_flags[`PMIR_BIT_SHUTDOWN] = 1'b0;
    end

    // Interrupt flags, set wins over clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
            flags_r <= `PMIR_FLAGS_RESET;
        else
        begin
            flags_r <= flags_r & ~clr_flags;
            if (fault_rise)
                flags_r[`PMIR_BIT_FAULT] <= 1'b1;
            if (shutdown_event || cause_new)
                flags_r[`PMIR_BIT_SHUTDOWN] <= 1'b1;
            if (hot_rise)
                flags_r[`PMIR_BIT_HOT_DIE] <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            mask_r <= `PMIR_MASK_RESET;
        else if (wr_mask)
            mask_r <= (reg_wdata & `PMIR_IMPL_BITS) | ~`PMIR_IMPL_BITS;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            status_r <= `PMIR_STATUS_RESET;
        else
            status_r <= {7'h00, hot_temp};
    end

    assign irq_nxt = |(flags_r & ~mask_r & `PMIR_IMPL_BITS);

    always_ff @(posedge clk)
    begin
        if (!resetn)
            interrupt_out_n <= 1'b1;
        else
            interrupt_out_n <= ~irq_nxt;
    end

    always_comb
    begin
        if (hit(reg_addr, `PMIR_OFF_IDENT_LOW))
            rdata_nxt = 8'(`PMIR_PART_NUMBER);
        else if (hit(reg_addr, `PMIR_OFF_IDENT_HIGH))
            rdata_nxt = {`PMIR_SILICON_REVISION, variant, 4'(`PMIR_PART_NUMBER >> 8)};
        else if (hit(reg_addr, `PMIR_OFF_INT_FLAGS))
            rdata_nxt = flags_r;
        else if (hit(reg_addr, `PMIR_OFF_INT_MASK))
            rdata_nxt = mask_r;
        else if (hit(reg_addr, `PMIR_OFF_CHIP_STATUS))
            rdata_nxt = status_r;
        else if (hit(reg_addr, `PMIR_OFF_SHUTDOWN_CAUSE))
            rdata_nxt = {4'h0, cause_r};
        else
            rdata_nxt = 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_nxt;
    end

    assign shutdown_cause = cause_r;

    // Properties on interrupt output, flags, mask, status, shutdown cause and read data
    a_irq_follows: assert property (@(posedge clk) disable iff (!resetn)
        (|(flags_r & ~mask_r & `PMIR_IMPL_BITS)) |=> !interrupt_out_n)
        else $error("interrupt output not asserted");
    a_irq_release: assert property (@(posedge clk) disable iff (!resetn)
        !(|(flags_r & ~mask_r & `PMIR_IMPL_BITS)) |=> interrupt_out_n)
        else $error("interrupt output stuck");
    a_hot_sets: assert property (@(posedge clk) disable iff (!resetn)
        hot_rise |=> flags_r[`PMIR_BIT_HOT_DIE])
        else $error("hot-die flag not set");
    a_fault_sets: assert property (@(posedge clk) disable iff (!resetn)
        fault_rise |=> flags_r[`PMIR_BIT_FAULT])
        else $error("fault flag not set");
    a_shdn_sets: assert property (@(posedge clk) disable iff (!resetn)
        (shutdown_event || cause_new) |=> flags_r[`PMIR_BIT_SHUTDOWN])
        else $error("shutdown flag not set");
    a_shdn_hold: assert property (@(posedge clk) disable iff (!resetn)
        (flags_r[`PMIR_BIT_SHUTDOWN] && cause_r != 4'h0) |=> flags_r[`PMIR_BIT_SHUTDOWN])
        else $error("shutdown flag cleared early");
    a_flag_latch: assert property (@(posedge clk) disable iff (!resetn)
        (flags_r[`PMIR_BIT_HOT_DIE] && !wr_flags) |=> flags_r[`PMIR_BIT_HOT_DIE])
        else $error("flag dropped without clear");
    a_fault_latch: assert property (@(posedge clk) disable iff (!resetn)
        (flags_r[`PMIR_BIT_FAULT] && !wr_flags) |=> flags_r[`PMIR_BIT_FAULT])
        else $error("fault flag dropped without clear");
    a_shdn_latch: assert property (@(posedge clk) disable iff (!resetn)
        (flags_r[`PMIR_BIT_SHUTDOWN] && !wr_flags) |=> flags_r[`PMIR_BIT_SHUTDOWN])
        else $error("shutdown flag dropped without clear");
    a_w1c_clears: assert property (@(posedge clk) disable iff (!resetn)
        (wr_flags && reg_wdata[`PMIR_BIT_HOT_DIE] && !hot_rise) |=> !flags_r[`PMIR_BIT_HOT_DIE])
        else $error("hot-die flag not cleared by write one");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!resetn)
        ((flags_r & ~`PMIR_IMPL_BITS) == `PMIR_FLAGS_RESET) && ((mask_r & ~`PMIR_IMPL_BITS) == ~`PMIR_IMPL_BITS))
        else $error("reserved bits changed");
    a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_mask |=> mask_r == (($past(reg_wdata) & `PMIR_IMPL_BITS) | ~`PMIR_IMPL_BITS))
        else $error("mask write not taken");
    a_mask_reset: assert property (@(posedge clk)
        !resetn |=> mask_r == `PMIR_MASK_RESET && flags_r == `PMIR_FLAGS_RESET)
        else $error("bad reset values");
    a_status_live: assert property (@(posedge clk) disable iff (!resetn)
        hot_temp |=> status_r == {7'h00, 1'b1})
        else $error("status not live");
    a_status_drop: assert property (@(posedge clk) disable iff (!resetn)
        !hot_temp |=> status_r == `PMIR_STATUS_RESET)
        else $error("status latched");
    a_cause_crit: assert property (@(posedge clk) disable iff (!resetn)
        crit_rise |=> cause_r[`PMIR_CAUSE_CRIT])
        else $error("critical cause not set");
    a_ident_low: assert property (@(posedge clk) disable iff (!resetn)
        (reg_addr == `PMIR_OFF_IDENT_LOW) |=> reg_rdata == 8'(`PMIR_PART_NUMBER))
        else $error("ident low byte wrong");
    a_ident_high: assert property (@(posedge clk) disable iff (!resetn)
        (reg_addr == `PMIR_OFF_IDENT_HIGH) |=> reg_rdata == {`PMIR_SILICON_REVISION, `PMIR_VARIANT, 4'(`PMIR_PART_NUMBER >> 8)})
        else $error("ident high byte wrong");
endmodule : pmir_regs

/* File: tb/pmir_host_model.sv */
`timescale 1ns/10ps
module pmir_host_model
(
    input wire logic clk, // System clock
    output logic [7:0] reg_addr, // Offset
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata // Write data
);
    event got;
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #10 reg_wr = 1'b0;
        reg_wdata = ~d; // Released data is not held
        @(posedge clk);
        #10;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        @(posedge clk);
        #10 ->got;
    endtask : rd
endmodule : pmir_host_model

/* File: tb/tb.sv */
`timescale 1ns/10ps
`include "pmir_params.svh"
module tb;
    import pmir_pkg::*;
    logic clk, resetn, rail_fault, crit_temp, hot_temp, uvlo_event, shutdown_event;
    logic reg_wr, interrupt_out_n;
    logic [7:0] reg_addr, reg_wdata, r;
    pmir_byte_t reg_rdata;
    logic [3:0] shutdown_cause;
    logic [20:0] expq[$];
    logic [20:0] e;
    logic [3:0] exp_cause;
    logic [7:0] rst[8];
    int err_count = 0;
    int n_checks = 0;
    pmir_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    pmir_regs DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rail_fault(rail_fault), .crit_temp(crit_temp), .hot_temp(hot_temp),
        .uvlo_event(uvlo_event), .shutdown_event(shutdown_event), .shutdown_cause(shutdown_cause),
        .interrupt_out_n(interrupt_out_n));
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic n);
        expq.push_back({a, exp_cause, n, d});
        host.rd(a);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : idle
    always @(host.got)
    begin
        e = expq.pop_front();
        n_checks++;
        if ({shutdown_cause, interrupt_out_n, reg_rdata} !== e[12:0])
        begin
            err_count++;
            $display("MISMATCH cause,irq_n,rdata@%h expected %h seen %h", e[20:13], e[12:0],
                {shutdown_cause, interrupt_out_n, reg_rdata});
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #1000000;
        err_count++;
        final_report();
    end
    initial
    begin
        {resetn, rail_fault, crit_temp, hot_temp, uvlo_event, shutdown_event} = 6'h00;
        exp_cause = 4'h0;
        rst = '{8'(`PMIR_PART_NUMBER), {`PMIR_SILICON_REVISION, PMIR_VARIANT_B, 4'(`PMIR_PART_NUMBER >> 8)},
            8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(11));
        idle(16);
        resetn = 1'b1;
        foreach (rst[i]) rd(8'(i), rst[i], 1'b1);
        for (int i = 0; i < 8; i++) if (i != 3) host.wr(8'(i), 8'($urandom));
        foreach (rst[i]) rd(8'(i), rst[i], 1'b1);
        hot_temp = 1'b1;
        idle(3);
        rd(8'h04, 8'h01, 1'b1);
        rd(8'h02, 8'h01, 1'b1);
        repeat (4)
        begin
            r = 8'($urandom);
            host.wr(8'h03, r);
            rd(8'h03, r | 8'h76, r[0]);
        end
        hot_temp = 1'b0;
        host.wr(8'h03, 8'h00);
        host.wr(8'h02, 8'h00);
        rd(8'h02, 8'h01, 1'b0);
        rd(8'h04, 8'h00, 1'b0);
        host.wr(8'h02, 8'h01);
        rd(8'h02, 8'h00, 1'b1);
        host.wr(8'h03, 8'hFF);
        rail_fault = 1'b1;
        idle(3);
        rd(8'h02, 8'h80, 1'b1);
        host.wr(8'h03, 8'h7F);
        rd(8'h03, 8'h7F, 1'b0);
        host.wr(8'h02, 8'h80);
        rail_fault = 1'b0;
        rd(8'h02, 8'h00, 1'b1);
        crit_temp = 1'b1;
        idle(3);
        exp_cause = 4'h1;
        rd(8'h05, 8'h01, 1'b0);
        host.wr(8'h02, 8'h08);
        rd(8'h02, 8'h88, 1'b0);
        host.wr(8'h05, 8'h01);
        exp_cause = 4'h0;
        host.wr(8'h02, 8'h88);
        rd(8'h02, 8'h00, 1'b1);
        crit_temp = 1'b0;
        uvlo_event = 1'b1;
        idle(1);
        uvlo_event = 1'b0;
        idle(2);
        exp_cause = 4'h4;
        rd(8'h05, 8'h04, 1'b1);
        host.wr(8'h05, 8'h04);
        exp_cause = 4'h0;
        host.wr(8'h02, 8'h08);
        shutdown_event = 1'b1;
        idle(1);
        shutdown_event = 1'b0;
        idle(2);
        rd(8'h02, 8'h08, 1'b1);
        resetn = 1'b0;
        idle(2);
        resetn = 1'b1;
        foreach (rst[i]) rd(8'(i), rst[i], 1'b1);
        idle(1);
        if (expq.size() != 0)
        begin
            err_count++;
            $display("MISMATCH pending_notes expected 0 seen %0d", expq.size());
        end
        final_report();
    end
endmodule : tb
